// >>> src/smd_device.sv
// slave end: address match, ack, byte exchange, timeout and readiness
//
// Summary of operation
// - master clocks between 10 and 100 kHz
// - master waits out slave stretching, then drives the clock low as soon as it reads it high
// - device ready within 500 ms of reset
// - or ready after bus idle-high 2.5 s
// - clock low 25..35 ms flags timeout
// - slave stretching under 25 ms per message
// - master stretching under 10 ms per byte
// - bus free 4.7 us before new start
// - hold 4.0 us after start before clock
// - data changes only while clock low
// - always acknowledge own address byte
// - data bytes acked by user choice
// - first byte is address plus direction bit
// - reserved patterns never own address
// - alert response address never own address
// - also respond at default address
// - adopt address assigned by resolution
// - master clocks, commands, ends transfers
// - slave-only build here
// - bytes shifted most significant bit first
`timescale 1ns/1ns
module smd_device
    import smd_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYC = TIMEOUT_LINK_CYC,
    parameter int unsigned READY_CYC   = READY_LINK_CYC,
    parameter int unsigned POR_CYC     = POR_LINK_CYC,
    parameter int unsigned STRETCH_CYC = STRETCH_LINK_CYC,
    parameter logic        ARP_CAPABLE = 1'b1,
    parameter int unsigned CW          = 32
) (
    // link clock and reset
    input  wire logic       link_clk,
    input  wire logic       sys_rst,
    // bus
    smd_bus_if.dev          bus,
    // user side
    input  wire logic [6:0] new_addr,
    input  wire logic       new_addr_load,
    input  wire logic       data_ack,
    input  wire logic [7:0] tx_data,
    output logic [7:0]      rx_data,
    output logic            rx_valid,
    output logic            dev_ready,
    output logic            timeout_flag,
    output logic [6:0]      own_addr
);
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_TXACK, ST_IGNORE} smd_state_e;
    typedef struct packed {
        smd_state_e  st;
        logic        scl_d;
        logic        sda_d;
        logic [7:0]  shift;
        logic [2:0]  cnt;
        logic        seen;
        logic        rd;
        logic        ack_en;
        logic        dat_oe;
        logic [7:0]  rx_data;
        logic        rx_valid;
        logic [6:0]  addr;
        logic [CW-1:0] low_cnt;
        logic [CW-1:0] idle_cnt;
        logic [CW-1:0] por_cnt;
        logic        ready;
        logic        tmo;
    } smd_dev_s;
    smd_dev_s cur_ff;
    smd_dev_s nxt_ff;
    logic scl_s;
    logic sda_s;
    // lines come from the wired bus, resynchronise to the link clock
    smd_sync #(.RST_VAL(1'b1)) u_scl (.clk(link_clk), .rst(sys_rst), .din(bus.serial_clock_line), .dout(scl_s));
    smd_sync #(.RST_VAL(1'b1)) u_sda (.clk(link_clk), .rst(sys_rst), .din(bus.serial_data_line), .dout(sda_s));
    // user load strobe comes from another clock
    logic load_s;
    smd_sync #(.RST_VAL(1'b0)) u_load (.clk(link_clk), .rst(sys_rst), .din(new_addr_load), .dout(load_s));
    logic start_c;
    logic stop_c;
    logic rise_c;
    logic fall_c;
    logic addr_hit;
    always_comb
    begin
        start_c = cur_ff.scl_d & scl_s & cur_ff.sda_d & ~sda_s;
        stop_c  = cur_ff.scl_d & scl_s & ~cur_ff.sda_d & sda_s;
        rise_c  = ~cur_ff.scl_d & scl_s;
        fall_c  = cur_ff.scl_d & ~scl_s;
        addr_hit = (cur_ff.shift[7:1] == cur_ff.addr) | (ARP_CAPABLE & (cur_ff.shift[7:1] == ADDR_DEFAULT));
    end
    function automatic logic addr_legal(input logic [6:0] a);
        addr_legal = (a != ADDR_GEN_CALL) && (a != ADDR_CBUS) && ((a & ADDR_TENBIT_MSK) != ADDR_TENBIT)
                     && (a != ADDR_ALERT_RESP);
    endfunction : addr_legal
    always_comb
    begin
        nxt_ff          = cur_ff;
        nxt_ff.scl_d    = scl_s;
        nxt_ff.sda_d    = sda_s;
        nxt_ff.rx_valid = 1'b0;
        if (cur_ff.por_cnt != CW'(POR_CYC))
            nxt_ff.por_cnt = cur_ff.por_cnt + CW'(1);
        if (scl_s & sda_s)
        begin
            if (cur_ff.idle_cnt != CW'(READY_CYC))
                nxt_ff.idle_cnt = cur_ff.idle_cnt + CW'(1);
        end
        else
            nxt_ff.idle_cnt = '0;
        if ((cur_ff.por_cnt == CW'(POR_CYC)) | (cur_ff.idle_cnt == CW'(READY_CYC)))
            nxt_ff.ready = 1'b1;
        if (load_s && addr_legal(new_addr) && cur_ff.st == ST_IDLE)
            nxt_ff.addr = new_addr;
        if (scl_s)
            nxt_ff.low_cnt = '0;
        else if (cur_ff.low_cnt != CW'(TIMEOUT_CYC))
            nxt_ff.low_cnt = cur_ff.low_cnt + CW'(1);
        nxt_ff.tmo = (cur_ff.low_cnt == CW'(TIMEOUT_CYC));
        // timeout or not ready: release, idle
        if ((cur_ff.low_cnt == CW'(TIMEOUT_CYC)) || !cur_ff.ready)
        begin
            nxt_ff.st     = ST_IDLE;
            nxt_ff.dat_oe = 1'b0;
        end
        else if (start_c)
        begin
            nxt_ff.st     = ST_ADDR;
            nxt_ff.cnt    = '0;
            nxt_ff.seen   = 1'b0;
            nxt_ff.dat_oe = 1'b0;
        end
        else if (stop_c)
        begin
            nxt_ff.st     = ST_IDLE;
            nxt_ff.dat_oe = 1'b0;
        end
        else
        begin
            unique case (cur_ff.st)
                ST_IDLE, ST_IGNORE: nxt_ff.dat_oe = 1'b0;
                ST_ADDR, ST_RX:
                begin
                    if (rise_c)
                    begin
                        nxt_ff.shift = {cur_ff.shift[6:0], sda_s};
                        nxt_ff.cnt   = cur_ff.cnt + 3'h1;
                        nxt_ff.seen  = 1'b1;
                    end
                    if (fall_c && cur_ff.cnt == 3'h0 && cur_ff.seen)
                    begin
                        nxt_ff.seen = 1'b0;
                        if (cur_ff.st == ST_ADDR)
                        begin
                            // upper seven bits address, bit 0 direction
                            nxt_ff.rd = (cur_ff.shift[0] == DIR_READ);
                            nxt_ff.shift = {1'b0, cur_ff.shift[7:1]};
                            nxt_ff.ack_en = 1'b1;
                            if (addr_hit)
                            begin
                                nxt_ff.dat_oe = 1'b1;
                                nxt_ff.st     = ST_ACK;
                            end
                            else
                                // mismatch ignored till start or stop
                                nxt_ff.st = ST_IGNORE;
                        end
                        else
                        begin
                            nxt_ff.rx_data  = cur_ff.shift;
                            nxt_ff.rx_valid = 1'b1;
                            nxt_ff.dat_oe   = data_ack;
                            nxt_ff.rd       = 1'b0;
                            nxt_ff.st       = ST_ACK;
                        end
                    end
                end
                ST_ACK:
                begin
                    if (fall_c)
                    begin
                        nxt_ff.cnt = '0;
                        if (cur_ff.rd)
                        begin
                            nxt_ff.shift  = {tx_data[6:0], 1'b0};
                            nxt_ff.dat_oe = ~tx_data[7];
                            nxt_ff.st     = ST_TX;
                        end
                        else
                        begin
                            nxt_ff.dat_oe = 1'b0;
                            nxt_ff.st     = ST_RX;
                        end
                    end
                end
                ST_TX:
                begin
                    if (fall_c)
                    begin
                        nxt_ff.cnt = cur_ff.cnt + 3'h1;
                        if (cur_ff.cnt == BIT_LAST)
                        begin
                            nxt_ff.dat_oe = 1'b0;
                            nxt_ff.st     = ST_TXACK;
                        end
                        else
                        begin
                            nxt_ff.dat_oe = ~cur_ff.shift[7];
                            nxt_ff.shift  = {cur_ff.shift[6:0], 1'b0};
                        end
                    end
                end
                ST_TXACK:
                begin
                    if (rise_c)
                        nxt_ff.ack_en = ~sda_s;
                    if (fall_c)
                    begin
                        nxt_ff.cnt = '0;
                        if (cur_ff.ack_en)
                        begin
                            nxt_ff.shift  = {tx_data[6:0], 1'b0};
                            nxt_ff.dat_oe = ~tx_data[7];
                            nxt_ff.st     = ST_TX;
                        end
                        else
                            nxt_ff.st = ST_IGNORE;
                    end
                end
                default: nxt_ff.st = ST_IDLE;
            endcase
        end
    end
    always_ff @(posedge link_clk)
    begin
        if (sys_rst)
        begin
            cur_ff      <= '0;
            cur_ff.st   <= ST_IDLE;
            cur_ff.scl_d <= 1'b1;
            cur_ff.sda_d <= 1'b1;
            cur_ff.addr <= ADDR_INIT;
        end
        else
            cur_ff <= nxt_ff;
    end
    assign bus.dev_clk_oe = 1'b0;
    assign bus.dev_dat_oe = cur_ff.dat_oe;
    assign rx_data      = cur_ff.rx_data;
    assign rx_valid     = cur_ff.rx_valid;
    assign dev_ready    = cur_ff.ready;
    assign timeout_flag = cur_ff.tmo;
    assign own_addr     = cur_ff.addr;
endmodule : smd_device

// >>> src/smd_pkg.sv
// shared constants for the two-wire management bus ends
package smd_pkg;
    localparam int unsigned SYS_CLK_MHZ      = 250;
    localparam int unsigned LINK_CLK_MHZ     = 83;
    // bus rate limits, kHz
    localparam int unsigned BUS_FREQ_MIN_KHZ = 10;
    localparam int unsigned BUS_FREQ_MAX_KHZ = 100;
    // clock-low timeout window, slave stretch limit and ready times, ms
    localparam int unsigned TIMEOUT_MIN_MS   = 25;
    localparam int unsigned TIMEOUT_MAX_MS   = 35;
    localparam int unsigned SLAVE_STRETCH_MS = 25;
    localparam int unsigned POR_READY_MS     = 500;
    localparam int unsigned IDLE_READY_MS    = 2500;
    // master timing, ns
    localparam int unsigned BUS_FREE_NS      = 4700;
    localparam int unsigned START_HOLD_NS    = 4000;
    // derived counts on the link clock (device) and system clock (host)
    localparam int unsigned TIMEOUT_LINK_CYC = 30 * LINK_CLK_MHZ * 1000;
    localparam int unsigned READY_LINK_CYC   = IDLE_READY_MS * LINK_CLK_MHZ * 1000;
    localparam int unsigned POR_LINK_CYC     = POR_READY_MS * LINK_CLK_MHZ * 1000;
    localparam int unsigned STRETCH_LINK_CYC = SLAVE_STRETCH_MS * LINK_CLK_MHZ * 1000;
    localparam int unsigned BUS_FREE_SYS_CYC = (BUS_FREE_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int unsigned START_HOLD_SYS_CYC = (START_HOLD_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int unsigned TIMEOUT_SYS_CYC  = 30 * SYS_CLK_MHZ * 1000;
    // default half period for 100 kHz
    localparam int unsigned HALF_PER_SYS_CYC = (SYS_CLK_MHZ * 1000) / (2 * BUS_FREQ_MAX_KHZ);
    // reserved and special addresses, last bit index, read direction value
    localparam logic [6:0] ADDR_GEN_CALL   = 7'h00;
    localparam logic [6:0] ADDR_CBUS       = 7'h01;
    localparam logic [6:0] ADDR_ALERT_RESP = 7'h0C;
    localparam logic [6:0] ADDR_DEFAULT    = 7'h61;
    localparam logic [6:0] ADDR_TENBIT     = 7'h78;
    localparam logic [6:0] ADDR_TENBIT_MSK = 7'h7C;
    localparam logic [6:0] ADDR_INIT       = 7'h48;
    localparam logic [2:0] BIT_LAST        = 3'h7;
    localparam logic       DIR_READ        = 1'b1;
endpackage : smd_pkg

// >>> src/smd_bus_if.sv
// open-drain bus wires shared by host and device ends
`timescale 1ns/1ns
interface smd_bus_if;
    logic serial_clock_line;
    logic serial_data_line;
    logic host_clk_oe;
    logic host_dat_oe;
    logic dev_clk_oe;
    logic dev_dat_oe;
    // wired-and with pull-up
    assign serial_clock_line = ~(host_clk_oe | dev_clk_oe);
    assign serial_data_line  = ~(host_dat_oe | dev_dat_oe);
    modport host (input serial_clock_line, input serial_data_line, output host_clk_oe, output host_dat_oe);
    modport dev  (input serial_clock_line, input serial_data_line, output dev_clk_oe, output dev_dat_oe);
endinterface : smd_bus_if

// >>> src/smd_sync.sv
// two flip-flop synchroniser with a settable reset value
`timescale 1ns/1ns
module smd_sync #(
    parameter logic RST_VAL = 1'b1
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // data
    input  wire logic din,
    output logic      dout
);
    logic meta_ff;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_ff <= RST_VAL;
            dout    <= RST_VAL;
        end
        else
        begin
            meta_ff <= din;
            dout    <= meta_ff;
        end
    end
endmodule : smd_sync

// >>> src/smd_host.sv
// master end: start, address, one data byte, stop, clock from a divider
`timescale 1ns/1ns
module smd_host
    import smd_pkg::*;
#(
    parameter int unsigned HALF_CYC    = HALF_PER_SYS_CYC,
    parameter int unsigned TIMEOUT_CYC = TIMEOUT_SYS_CYC,
    parameter int unsigned CW          = 32
) (
    // system clock and reset
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    // bus
    smd_bus_if.host         bus,
    // user request
    input  wire logic       req,
    input  wire logic [6:0] req_addr,
    input  wire logic       req_rd,
    input  wire logic [7:0] req_data,
    output logic            busy,
    output logic            done,
    output logic            addr_acked,
    output logic [7:0]      rd_data,
    output logic            timeout_flag
);
    typedef enum logic [2:0] {HS_FREE, HS_START, HS_BIT, HS_STOP} smd_hstate_e;
    typedef struct packed {
        smd_hstate_e st;
        logic [CW-1:0] tmr;
        logic [CW-1:0] low_cnt;
        logic [4:0]  bitn;
        logic        phase;
        logic [17:0] sh;
        logic        rd;
        logic        clk_oe;
        logic        dat_oe;
        logic        busy;
        logic        done;
        logic        acked;
        logic [7:0]  rdat;
        logic        tmo;
    } smd_host_s;
    smd_host_s cur_ff;
    smd_host_s nxt_ff;
    logic scl_s;
    logic sda_s;
    smd_sync #(.RST_VAL(1'b1)) u_scl (.clk(sys_clk), .rst(sys_rst), .din(bus.serial_clock_line), .dout(scl_s));
    smd_sync #(.RST_VAL(1'b1)) u_sda (.clk(sys_clk), .rst(sys_rst), .din(bus.serial_data_line), .dout(sda_s));
    always_comb
    begin
        nxt_ff      = cur_ff;
        nxt_ff.done = 1'b0;
        if (cur_ff.tmr != '0)
            nxt_ff.tmr = cur_ff.tmr - CW'(1);
        if (scl_s)
            nxt_ff.low_cnt = '0;
        else if (cur_ff.low_cnt != CW'(TIMEOUT_CYC))
            nxt_ff.low_cnt = cur_ff.low_cnt + CW'(1);
        nxt_ff.tmo = (cur_ff.low_cnt == CW'(TIMEOUT_CYC));
        if (cur_ff.low_cnt == CW'(TIMEOUT_CYC))
        begin
            nxt_ff.st     = HS_FREE;
            nxt_ff.clk_oe = 1'b0;
            nxt_ff.dat_oe = 1'b0;
            nxt_ff.busy   = 1'b0;
            nxt_ff.tmr    = CW'(BUS_FREE_SYS_CYC);
        end
        else
        begin
            unique case (cur_ff.st)
                HS_FREE:
                    if (req && cur_ff.tmr == '0)
                    begin
                        nxt_ff.sh     = {req_addr, req_rd, 1'b1, req_data, 1'b1};
                        nxt_ff.rd     = req_rd;
                        nxt_ff.busy   = 1'b1;
                        nxt_ff.acked  = 1'b0;
                        nxt_ff.dat_oe = 1'b1;
                        nxt_ff.st     = HS_START;
                        nxt_ff.tmr    = CW'(START_HOLD_SYS_CYC);
                    end
                HS_START:
                    if (cur_ff.tmr == '0)
                    begin
                        nxt_ff.clk_oe = 1'b1;
                        nxt_ff.bitn   = '0;
                        nxt_ff.phase  = 1'b0;
                        nxt_ff.st     = HS_BIT;
                        nxt_ff.tmr    = CW'(HALF_CYC);
                    end
                HS_BIT:
                begin
                    // change data mid clock low; read bytes get a nack
                    if (!cur_ff.phase && cur_ff.tmr == CW'(HALF_CYC / 2))
                        nxt_ff.dat_oe = ~cur_ff.sh[17] & ~(cur_ff.rd && cur_ff.bitn >= 5'd9);
                    if (cur_ff.tmr == '0)
                    begin
                        nxt_ff.tmr = CW'(HALF_CYC);
                        if (!cur_ff.phase)
                        begin
                            nxt_ff.clk_oe = 1'b0;
                            nxt_ff.phase  = 1'b1;
                        end
                        else if (scl_s)
                        begin
                            if (cur_ff.bitn == 5'd8)
                                nxt_ff.acked = ~sda_s;
                            if (cur_ff.bitn >= 5'd9 && cur_ff.bitn < 5'd17)
                                nxt_ff.rdat = {cur_ff.rdat[6:0], sda_s};
                            nxt_ff.sh     = {cur_ff.sh[16:0], 1'b1};
                            nxt_ff.clk_oe = 1'b1;
                            nxt_ff.phase  = 1'b0;
                            nxt_ff.bitn   = cur_ff.bitn + 5'd1;
                            if (cur_ff.bitn == 5'd17 || (cur_ff.bitn == 5'd8 && sda_s))
                                nxt_ff.st = HS_STOP;
                        end
                        else
                            nxt_ff.tmr = '0;
                    end
                end
                HS_STOP:
                begin
                    if (cur_ff.clk_oe && cur_ff.tmr == CW'(HALF_CYC / 2))
                        nxt_ff.dat_oe = 1'b1;
                    if (cur_ff.tmr == '0)
                    begin
                        if (cur_ff.clk_oe)
                        begin
                            nxt_ff.clk_oe = 1'b0;
                            nxt_ff.tmr    = CW'(HALF_CYC);
                        end
                        else
                        begin
                            nxt_ff.dat_oe = 1'b0;
                            nxt_ff.busy   = 1'b0;
                            nxt_ff.done   = 1'b1;
                            nxt_ff.st     = HS_FREE;
                            nxt_ff.tmr    = CW'(BUS_FREE_SYS_CYC);
                        end
                    end
                end
                default: nxt_ff.st = HS_FREE;
            endcase
        end
    end
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            cur_ff    <= '0;
            cur_ff.st <= HS_FREE;
        end
        else
            cur_ff <= nxt_ff;
    end
    assign bus.host_clk_oe = cur_ff.clk_oe;
    assign bus.host_dat_oe = cur_ff.dat_oe;
    assign busy         = cur_ff.busy;
    assign done         = cur_ff.done;
    assign addr_acked   = cur_ff.acked;
    assign rd_data      = cur_ff.rdat;
    assign timeout_flag = cur_ff.tmo;
endmodule : smd_host

// >>> tb/smd_bus_properties.sv
// concurrent checks on the shared bus wires
`timescale 1ns/1ns
module smd_bus_properties
    import smd_pkg::*;
#(
    parameter int unsigned HALF_CYC = HALF_PER_SYS_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // bus wires
    input wire logic serial_clock_line,
    input wire logic serial_data_line,
    input wire logic host_clk_oe,
    input wire logic host_dat_oe,
    input wire logic dev_clk_oe,
    input wire logic dev_dat_oe
);
    logic        scl_ff, sda_ff, pend_ff, start_c, stop_c;
    logic [15:0] run_ff, stop_ff, start_ff;
    assign start_c = scl_ff & serial_clock_line & sda_ff & ~serial_data_line;
    assign stop_c  = scl_ff & serial_clock_line & ~sda_ff & serial_data_line;
    // stable-clock run, time since stop and since start
    always_ff @(posedge sys_clk)
    begin
        scl_ff   <= serial_clock_line;
        sda_ff   <= serial_data_line;
        run_ff   <= sys_rst ? 16'hFFFF : (serial_clock_line != scl_ff) ? 16'h0 : run_ff + {15'h0, run_ff != 16'hFFFF};
        stop_ff  <= sys_rst ? 16'hFFFF : stop_c ? 16'h0 : stop_ff + {15'h0, stop_ff != 16'hFFFF};
        start_ff <= sys_rst ? 16'hFFFF : start_c ? 16'h0 : start_ff + {15'h0, start_ff != 16'hFFFF};
        pend_ff  <= sys_rst ? 1'b0 : start_c ? 1'b1 : (scl_ff & ~serial_clock_line) ? 1'b0 : pend_ff;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    a_dev_no_stretch: assert property (!dev_clk_oe)
        else $error("device pulled the clock low");
    a_master_clocks: assert property (!serial_clock_line |-> host_clk_oe)
        else $error("clock low without host driving it");
    a_dev_set_low: assert property ($rose(dev_dat_oe) |-> !serial_clock_line)
        else $error("device took data while clock high");
    a_dev_rel_low: assert property ($fell(dev_dat_oe) |-> !serial_clock_line)
        else $error("device released data while clock high");
    a_clk_low_min: assert property ($rose(serial_clock_line) |-> run_ff >= HALF_CYC - 2)
        else $error("clock low phase too short");
    a_clk_high_min: assert property ($fell(serial_clock_line) |-> run_ff >= HALF_CYC - 2)
        else $error("clock high phase too short");
    a_start_hold: assert property ($fell(serial_clock_line) && pend_ff |-> start_ff >= START_HOLD_SYS_CYC - 1)
        else $error("first clock too soon after start");
    a_bus_free: assert property (start_c |-> stop_ff >= BUS_FREE_SYS_CYC - 1)
        else $error("start too soon after stop");
endmodule : smd_bus_properties

// >>> tb/tb_top.sv
// self-checking bench: host and device joined on one bus
`timescale 1ns/1ns
module tb_top;
    import smd_pkg::*;
    localparam int unsigned HALF = 25;
    logic       sys_clk, link_clk, sys_rst, req, req_rd, new_addr_load, data_ack;
    logic       busy, done, addr_acked, rx_valid, dev_ready, h_to, d_to;
    logic [6:0] req_addr, new_addr, own_addr, cur_own, m;
    logic [7:0] req_data, tx_data, rx_data, rd_data, rx_last;
    logic [6:0] rsv [5] = '{7'h00, 7'h01, 7'h0C, 7'h78, 7'h7B};
    int         errors, check_count, rx_cnt, n, seed_v;
    smd_bus_if bus ();
    smd_host #(.HALF_CYC(HALF), .TIMEOUT_CYC(200)) i_smd_host (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(bus),
        .req(req), .req_addr(req_addr), .req_rd(req_rd), .req_data(req_data), .busy(busy), .done(done),
        .addr_acked(addr_acked), .rd_data(rd_data), .timeout_flag(h_to));
    smd_device #(.TIMEOUT_CYC(200), .READY_CYC(50), .POR_CYC(20)) i_smd_device (.link_clk(link_clk),
        .sys_rst(sys_rst), .bus(bus), .new_addr(new_addr), .new_addr_load(new_addr_load), .data_ack(data_ack),
        .tx_data(tx_data), .rx_data(rx_data), .rx_valid(rx_valid), .dev_ready(dev_ready), .timeout_flag(d_to),
        .own_addr(own_addr));
    smd_bus_properties #(.HALF_CYC(HALF)) i_smd_bus_properties (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .serial_clock_line(bus.serial_clock_line), .serial_data_line(bus.serial_data_line),
        .host_clk_oe(bus.host_clk_oe), .host_dat_oe(bus.host_dat_oe), .dev_clk_oe(bus.dev_clk_oe),
        .dev_dat_oe(bus.dev_dat_oe));
    initial sys_clk = 1'b0;
    always #2 sys_clk = ~sys_clk;
    // odd edges never meet the system clock
    initial
    begin
        link_clk = 1'b0;
        #1;
        forever #6 link_clk = ~link_clk;
    end
    always @(negedge link_clk)
    begin
        if (rx_valid === 1'b1)
        begin
            rx_last <= rx_data;
            rx_cnt  <= rx_cnt + 1;
        end
    end
    task automatic tally_and_finish;
        if (errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish
    task automatic chk_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t flag got %b exp %b", $time, got, exp);
        end
    endtask : chk_bit
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t value got %h exp %h", $time, got, exp);
        end
    endtask : chk_byte
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic wait_lim(input int lim);
        if (n >= lim)
        begin
            errors++;
            $display("[ERR] %0t wait limit reached", $time);
            tally_and_finish;
        end
    endtask : wait_lim
    task automatic xfer(input logic [6:0] a, input logic rd, input logic [7:0] d);
        int  c0;
        logic ack;
        ack      = (a == cur_own) || (a == ADDR_DEFAULT);
        c0       = rx_cnt;
        req_addr = a;
        req_rd   = rd;
        req_data = d;
        tx_data  = d;
        data_ack = 1'($urandom);
        req      = 1'b1;
        n = 0;
        while (busy !== 1'b1 && n < 2000)
        begin
            tick(1);
            n++;
        end
        req = 1'b0;
        while (done !== 1'b1 && n < 8000)
        begin
            tick(1);
            n++;
        end
        wait_lim(8000);
        chk_bit(addr_acked, ack);
        chk_bit(h_to, 1'b0);
        chk_bit(d_to, 1'b0);
        if (rd && ack)
            chk_byte(rd_data, d);
        if (!rd)
            chk_byte(8'(rx_cnt - c0), {7'h0, ack});
        if (!rd && ack)
            chk_byte(rx_last, d);
        tick(BUS_FREE_SYS_CYC + 20);
    endtask : xfer
    task automatic load(input logic [6:0] a);
        new_addr      = a;
        new_addr_load = 1'b1;
        tick(12);
        new_addr_load = 1'b0;
        tick(12);
    endtask : load
    initial
    begin
        {sys_rst, req, req_rd, new_addr_load, data_ack} = 5'b10000;
        {req_addr, new_addr, req_data, tx_data} = '0;
        {errors, check_count, rx_cnt} = '0;
        cur_own = ADDR_INIT;
        seed_v  = $urandom(79);
        // one rising link edge falls inside the reset
        tick(4);
        sys_rst = 1'b0;
        chk_byte({1'b0, own_addr}, 8'h48);
        chk_bit(d_to, 1'b0);
        n = 0;
        while (dev_ready !== 1'b1 && n < 1000)
        begin
            tick(1);
            n++;
        end
        chk_bit(dev_ready, 1'b1);
        for (int i = 0; i < 9; i++)
        begin
            m = 7'($urandom) | 7'h20;
            if (m == cur_own || m == ADDR_DEFAULT)
                m = m ^ 7'h10;
            xfer((i % 3 == 0) ? cur_own : (i % 3 == 1) ? ADDR_DEFAULT : m, 1'($urandom), 8'($urandom));
        end
        xfer(cur_own, 1'b0, 8'h80);
        xfer(cur_own, 1'b1, 8'h01);
        foreach (rsv[i])
        begin
            load(rsv[i]);
            chk_byte({1'b0, own_addr}, {1'b0, cur_own});
        end
        load(7'h25);
        cur_own = 7'h25;
        chk_byte({1'b0, own_addr}, 8'h25);
        xfer(7'h25, 1'b0, 8'($urandom));
        xfer(ADDR_INIT, 1'b0, 8'h5A);
        tally_and_finish;
    end
endmodule : tb_top
